/* File: logic/pcc_port_regs.v */
// Per-port common control register bank with an Avalon-MM slave.
// Assumes clk at 10 MHz and a datapath that consumes the control outputs.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pcc_defines.vh"

module pcc_port_regs #(
    parameter PORT_ID = 2'h0
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Avalon-MM slave
    input wire [11:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Chip-wide controls
    input wire global_reset,
    input wire global_error_insert,
    input wire global_counter_update,
    input wire counter_hold_done,
    // Datapath signal sources
    input wire rx_gapped_clock,
    input wire rx_clock_output,
    input wire rx_frame_start_out,
    input wire rx_data_enable,
    input wire tx_gapped_clock,
    input wire tx_clock_output,
    input wire tx_line_clock,
    input wire tx_positive_out,
    input wire tx_negative_out,
    input wire diagnostic_loopback,
    input wire payload_alarm_cond,
    input wire line_alarm_cond,
    // Control outputs
    output reg [2:0] payload_alarm_select,
    output reg payload_all_ones,
    output reg [1:0] line_alarm_select,
    output reg line_alarm_force,
    output reg pattern_tester_enable,
    output reg pattern_tester_clk_en,
    output reg error_insert_pulse,
    output reg counter_update_pulse,
    output reg port_power_down,
    output reg port_clk_en,
    output reg datapath_reset,
    output reg port_reset,
    output reg tx_line_clock_pin,
    output reg tx_positive_pin,
    output reg tx_negative_pin,
    output reg tx_diff_oe_b,
    output reg rx_monitor_gain,
    output reg tx_build_out_active,
    output reg [2:0] interface_mode_sel,
    output reg [2:0] framing_mode_sel,
    output reg rx_clock_pin,
    output reg rx_frame_pin,
    output reg tx_clock_pin
);

    // ****************************************
    // Registers
    // ****************************************
    reg [15:0] ctrl1_r;
    reg [15:0] ctrl2_r;
    reg [15:0] ctrl3_r;
    reg [15:0] ctrl4_r;
    reg [15:0] inv1_r;
    reg [15:0] inv2_r;
    reg done_r;
    reg mei_src_d_r;
    reg pmu_src_d_r;
    reg [15:0] rdata_nxt;
    reg hit;

    wire port_hit;
    wire [7:0] ofs;
    wire wr_stb;
    wire soft_rst;
    wire mei_src;
    wire pmu_src;
    wire [15:0] wdata;

    // Merge of write data through byte enables.
    function [15:0] pcc_merge;
        input [15:0] old;
        input [15:0] nw;
        input [15:0] mask;
        input [1:0] be;
        reg [15:0] lane;
        begin
            lane = {{8{be[1]}}, {8{be[0]}}};
            pcc_merge = ((old & ~lane) | (nw & lane)) & mask;
        end
    endfunction

    assign port_hit = (avs_address[11:9] == {1'b0, PORT_ID[1:0]}) && (avs_address[8] == 1'b0);
    assign ofs = avs_address[7:0];
    // Writes land at the edge that ends the wait, where the master sees the answer.
    assign wr_stb = avs_write && !avs_waitrequest && port_hit;
    assign wdata = avs_writedata[15:0];

    // effective reset from full and global; the pin resets asynchronously
    assign soft_rst = ctrl1_r[`PCC_C1_RST] | global_reset;

    assign mei_src = ctrl1_r[`PCC_C1_ERROR_INSERT_MODE] ? global_error_insert : ctrl1_r[`PCC_C1_MEI];
    assign pmu_src = ctrl1_r[`PCC_C1_COUNTER_UPDATE_MODE] ? global_counter_update : ctrl1_r[`PCC_C1_PMU];

    // ****************************************
    // Bus slave: one wait cycle, then answer
    // ****************************************
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always @*
    begin
        rdata_nxt = 16'h0000;
        hit = port_hit;
        case (ofs)
            `PCC_OFS_CTRL1: rdata_nxt = ctrl1_r;
            `PCC_OFS_CTRL2: rdata_nxt = ctrl2_r;
            `PCC_OFS_CTRL3: rdata_nxt = ctrl3_r;
            `PCC_OFS_CTRL4: rdata_nxt = ctrl4_r;
            `PCC_OFS_INV1: rdata_nxt = inv1_r;
            `PCC_OFS_INV2: rdata_nxt = inv2_r;
            `PCC_OFS_SR: rdata_nxt = {15'h0000, done_r};
            default: rdata_nxt = 16'h0000;
        endcase
        if (!hit)
            rdata_nxt = 16'h0000;
    end

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= {16'h0000, rdata_nxt};
    end

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl1_r <= `PCC_C1_RESET;
            ctrl2_r <= `PCC_C2_RESET;
            ctrl3_r <= `PCC_C3_RESET;
            ctrl4_r <= 16'h0000;
            inv1_r <= 16'h0000;
            inv2_r <= 16'h0000;
        end
        else
        begin
            if (wr_stb && ofs == `PCC_OFS_CTRL1)
                ctrl1_r <= pcc_merge(ctrl1_r, wdata, `PCC_C1_MASK, avs_byteenable[1:0]);
            // full reset defaults all but itself
            // datapath reset bit returns to one
            else if (soft_rst)
                ctrl1_r <= (`PCC_C1_RESET & ~16'h0001) | (ctrl1_r & 16'h0001);
            if (soft_rst)
            begin
                ctrl2_r <= `PCC_C2_RESET;
                ctrl3_r <= `PCC_C3_RESET;
                ctrl4_r <= 16'h0000;
                inv1_r <= 16'h0000;
                inv2_r <= 16'h0000;
            end
            else if (wr_stb)
            begin
                case (ofs)
                    `PCC_OFS_CTRL2: ctrl2_r <= pcc_merge(ctrl2_r, wdata, `PCC_C2_MASK, avs_byteenable[1:0]);
                    `PCC_OFS_CTRL3: ctrl3_r <= pcc_merge(ctrl3_r, wdata, `PCC_C3_MASK, avs_byteenable[1:0]);
                    `PCC_OFS_CTRL4: ctrl4_r <= pcc_merge(ctrl4_r, wdata, `PCC_C4_MASK, avs_byteenable[1:0]);
                    `PCC_OFS_INV1: inv1_r <= pcc_merge(inv1_r, wdata, `PCC_INV1_MASK, avs_byteenable[1:0]);
                    `PCC_OFS_INV2: inv2_r <= pcc_merge(inv2_r, wdata, `PCC_INV2_MASK, avs_byteenable[1:0]);
                    default: ctrl2_r <= ctrl2_r;
                endcase
            end
        end
    end

    // ****************************************
    // Edge detection and update handshake
    // ****************************************
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mei_src_d_r <= 1'b0;
            pmu_src_d_r <= 1'b0;
            error_insert_pulse <= 1'b0;
            counter_update_pulse <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            mei_src_d_r <= mei_src;
            pmu_src_d_r <= pmu_src;
            error_insert_pulse <= mei_src & ~mei_src_d_r & ~soft_rst;
            counter_update_pulse <= pmu_src & ~pmu_src_d_r & ~soft_rst;
            // done sets, clears when request drops
            if (soft_rst || !pmu_src)
                done_r <= 1'b0;
            else if (counter_hold_done)
                done_r <= 1'b1;
        end
    end

    // ****************************************
    // Datapath control outputs
    // ****************************************
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            payload_alarm_select <= `PCC_PAY_ALWAYS;
            payload_all_ones <= 1'b1;
            line_alarm_select <= `PCC_LINE_ON_DLB;
            line_alarm_force <= 1'b0;
            pattern_tester_enable <= 1'b0;
            pattern_tester_clk_en <= 1'b0;
            port_power_down <= 1'b1;
            port_clk_en <= 1'b0;
            datapath_reset <= 1'b1;
            port_reset <= 1'b1;
            tx_line_clock_pin <= 1'b0;
            tx_positive_pin <= 1'b0;
            tx_negative_pin <= 1'b0;
            tx_diff_oe_b <= 1'b1;
            rx_monitor_gain <= 1'b0;
            tx_build_out_active <= 1'b0;
            interface_mode_sel <= `PCC_LM_DISABLED;
            framing_mode_sel <= `PCC_FM_CBIT;
            rx_clock_pin <= 1'b0;
            rx_frame_pin <= 1'b0;
            tx_clock_pin <= 1'b0;
        end
        else
        begin
            payload_alarm_select <= ctrl1_r[`PCC_C1_PAY_HI:`PCC_C1_PAY_LO];
            payload_all_ones <= (ctrl1_r[`PCC_C1_PAY_HI:`PCC_C1_PAY_LO] == `PCC_PAY_ALWAYS) | payload_alarm_cond;
            // line alarm overrides framer, even in loopback
            line_alarm_select <= ctrl1_r[`PCC_C1_LINE_HI:`PCC_C1_LINE_LO];
            line_alarm_force <= (ctrl1_r[`PCC_C1_LINE_HI:`PCC_C1_LINE_LO] == `PCC_LINE_ON_DLB)
                ? diagnostic_loopback : line_alarm_cond;
            pattern_tester_enable <= ctrl1_r[`PCC_C1_BERT];
            pattern_tester_clk_en <= ctrl1_r[`PCC_C1_BERT] & ~ctrl1_r[`PCC_C1_PD];
            port_power_down <= ctrl1_r[`PCC_C1_PD];
            port_clk_en <= ~ctrl1_r[`PCC_C1_PD];
            datapath_reset <= ctrl1_r[`PCC_C1_DATAPATH_SOFT_RESET] | soft_rst;
            port_reset <= soft_rst;
            tx_line_clock_pin <= ctrl2_r[`PCC_C2_TX_LINE_OUTPUT_ENABLE] & tx_line_clock;
            tx_positive_pin <= ctrl2_r[`PCC_C2_TX_LINE_OUTPUT_ENABLE] & tx_positive_out;
            tx_negative_pin <= ctrl2_r[`PCC_C2_TX_LINE_OUTPUT_ENABLE] & tx_negative_out;
            tx_diff_oe_b <= (ctrl2_r[`PCC_C2_LM_HI:`PCC_C2_LM_LO] == `PCC_LM_DISABLED) | ctrl1_r[`PCC_C1_PD]
                | ctrl2_r[`PCC_C2_TTS];
            rx_monitor_gain <= ctrl2_r[`PCC_C2_RX_MONITOR_GAIN];
            tx_build_out_active <= ctrl2_r[`PCC_C2_TX_BUILD_OUT]
                & (ctrl2_r[`PCC_C2_LM_HI:`PCC_C2_LM_LO] == `PCC_LM_DS3);
            interface_mode_sel <= ctrl2_r[`PCC_C2_LM_HI:`PCC_C2_LM_LO];
            framing_mode_sel <= ctrl2_r[`PCC_C2_FM_HI:`PCC_C2_FM_LO];
            rx_clock_pin <= ctrl3_r[`PCC_C3_RX_CLOCK_OUT_SEL] ? rx_clock_output : rx_gapped_clock;
            rx_frame_pin <= ctrl3_r[`PCC_C3_RX_FRAME_PULSE_SEL] ? rx_frame_start_out : rx_data_enable;
            tx_clock_pin <= ctrl3_r[`PCC_C3_TX_CLOCK_OUT_SEL] ? tx_clock_output : tx_gapped_clock;
        end
    end

endmodule // pcc_port_regs

/* File: logic/pcc_defines.vh */
// Constants for the per-port common control register bank.
// Assumes a 16-bit register view placed in the low bits of a 32-bit Avalon-MM word.
//
// What this block does
// - Payload alarm select field in control 1 bits 14:12 forces all-ones on receive data.
// - Line alarm select field in bits 11:10 forces framed or unframed alarm on transmit line.
// - Pattern tester enable replaces transmit serial input; clear disables and gates it.
// - Rising manual error insert bit with mode zero injects one error.
// - Error insert mode picks port bit or chip-wide global insert source.
// - Counter update mode picks port bit or chip-wide global update control.
// - Rising update request with mode zero latches counters into holding and clears them.
// - Software holds request until done sets; done clears when request returns low.
// - Power-down bit, resetting to one, stops port clocks; zero restores operation.
// - Datapath reset bit holds datapath at default; reads one after any general reset.
// - Full reset bit forces all port registers to default except itself.
// - Effective port reset is full reset OR global reset OR inverted reset pin.
// - Transmit line output enable zero forces line clock and data outputs low.
// - Driver float bit floats differential outputs only while line interface is powered.
// - Receive monitor gain bit enables about 20 dB pre-amplifier.
// - Transmit build-out shapes waveform short cable, only in DS3 interface mode.
// - Interface mode field bits 10:8; reset value disables line interface and jitter attenuator.
// - Framing mode field bits 5:3 defaults to DS3 C-bit framing.
// - Receive clock output select routes gapped clock or continuous clock to shared pin.
// - Receive frame pulse select routes data enable or start-of-frame to shared pin.
// - Transmit clock output select routes gapped or continuous transmit clock.
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PCC_OFS_CTRL1 8'h40
`define PCC_OFS_CTRL2 8'h42
`define PCC_OFS_CTRL3 8'h44
`define PCC_OFS_CTRL4 8'h46
`define PCC_OFS_INV1 8'h4a
`define PCC_OFS_INV2 8'h4c
`define PCC_OFS_ISR 8'h50
`define PCC_OFS_SR 8'h52
`define PCC_OFS_SRL 8'h54
`define PCC_OFS_SRIE 8'h56

// ****************************************
// Control 1 fields
// ****************************************
`define PCC_C1_PAY_HI 14
`define PCC_C1_PAY_LO 12
`define PCC_C1_LINE_HI 11
`define PCC_C1_LINE_LO 10
`define PCC_C1_BERT 9
`define PCC_C1_MEI 7
`define PCC_C1_ERROR_INSERT_MODE 6
`define PCC_C1_COUNTER_UPDATE_MODE 4
`define PCC_C1_PMU 3
`define PCC_C1_PD 2
`define PCC_C1_DATAPATH_SOFT_RESET 1
`define PCC_C1_RST 0
`define PCC_C1_MASK 16'h7edf
`define PCC_C1_RESET 16'h0006

// ****************************************
// Control 2 fields
// ****************************************
`define PCC_C2_TX_LINE_OUTPUT_ENABLE 15
`define PCC_C2_TTS 14
`define PCC_C2_RX_MONITOR_GAIN 13
`define PCC_C2_TX_BUILD_OUT 12
`define PCC_C2_LM_HI 10
`define PCC_C2_LM_LO 8
`define PCC_C2_FM_HI 5
`define PCC_C2_FM_LO 3
`define PCC_C2_MASK 16'hf738
`define PCC_C2_RESET 16'h0000

// ****************************************
// Control 3 fields
// ****************************************
`define PCC_C3_RX_CLOCK_OUT_SEL 13
`define PCC_C3_RX_FRAME_PULSE_SEL 12
`define PCC_C3_TX_CLOCK_OUT_SEL 10
`define PCC_C3_MASK 16'h36ff
`define PCC_C3_RESET 16'h0000

// ****************************************
// Other masks and status bits
// ****************************************
`define PCC_C4_MASK 16'h07ff
`define PCC_INV1_MASK 16'h17ff
`define PCC_INV2_MASK 16'h16de
`define PCC_SR_DONE 0
`define PCC_LM_DISABLED 3'h0
`define PCC_LM_DS3 3'h1
`define PCC_FM_CBIT 3'h0
`define PCC_PAY_ALWAYS 3'h0
`define PCC_LINE_ON_DLB 2'h0

// ****************************************
// Timing
// ****************************************
`define PCC_CLK_NS 100
`define PCC_SOFT_RESET_MIN_NS 100
`define PCC_SOFT_RESET_CYC ((`PCC_SOFT_RESET_MIN_NS + `PCC_CLK_NS - 1) / `PCC_CLK_NS)

`endif

/* File: test/pcc_port_regs_properties.sv */
// Checker of bus and control relations at the bank ports.
// Assumes it is bound to every instance of pcc_port_regs.
`timescale 1ns/1ps
module pcc_port_props (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Bus
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    // Chip-wide and sources
    input wire global_reset,
    input wire diagnostic_loopback,
    input wire payload_alarm_cond,
    input wire line_alarm_cond,
    // Controls
    input wire [2:0] payload_alarm_select,
    input wire payload_all_ones,
    input wire [1:0] line_alarm_select,
    input wire line_alarm_force,
    input wire error_insert_pulse,
    input wire port_power_down,
    input wire port_clk_en,
    input wire datapath_reset,
    input wire port_reset,
    input wire tx_diff_oe_b,
    input wire tx_build_out_active,
    input wire [2:0] interface_mode_sel
);
// ****************************************
// Properties
// ****************************************
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_b);
a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("late answer");
a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
a_glob_reset: assert property (global_reset |=> port_reset && datapath_reset)
    else $error("no port reset");
a_pay_ones: assert property ($past(rst_b) |->
    payload_all_ones == (payload_alarm_select == 3'h0 || $past(payload_alarm_cond))) else $error("bad all-ones");
a_line_force: assert property ($past(rst_b) |-> line_alarm_force ==
    (line_alarm_select == 2'h0 ? $past(diagnostic_loopback) : $past(line_alarm_cond))) else $error("bad alarm");
a_driver_float: assert property (interface_mode_sel == 3'h0 || port_power_down |-> tx_diff_oe_b)
    else $error("driver on");
a_bout_ds3: assert property (tx_build_out_active |-> interface_mode_sel == 3'h1)
    else $error("build-out mode");
a_clk_stop: assert property (port_power_down |-> !port_clk_en)
    else $error("clock runs");
a_err_single: assert property (error_insert_pulse |=> !error_insert_pulse)
    else $error("long pulse");
c_err: cover property (error_insert_pulse);
c_greset: cover property (global_reset ##1 port_reset);
c_float: cover property (tx_diff_oe_b && interface_mode_sel != 3'h0);
endmodule // pcc_port_props

bind pcc_port_regs pcc_port_props u_props (.clk, .rst_b, .avs_read, .avs_write, .avs_waitrequest, .global_reset,
    .diagnostic_loopback, .payload_alarm_cond, .line_alarm_cond, .payload_alarm_select, .payload_all_ones,
    .line_alarm_select, .line_alarm_force, .error_insert_pulse, .port_power_down, .port_clk_en, .datapath_reset,
    .port_reset, .tx_diff_oe_b, .tx_build_out_active, .interface_mode_sel);

/* File: test/pcc_host_model.sv */
// Host processor model driving the Avalon-MM register port.
// Assumes a slave that lowers waitrequest to answer.
`timescale 1ns/1ps
module pcc_host_model (
    // Clock
    input wire clk,
    // Avalon-MM master
    output reg [11:0] avs_address,
    output reg avs_read,
    output reg avs_write,
    output reg [31:0] avs_writedata,
    output reg [3:0] avs_byteenable,
    input wire avs_waitrequest
);
// ****************************************
// Bus cycle
// ****************************************
initial
begin
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
end
// Holds the request until waitrequest is seen low.
task xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
begin
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
        @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
end
endtask
endmodule // pcc_host_model

/* File: test/tb_top.sv */
// Self-checking bench of the port control bank.
// Assumes the bank answers for port digit zero.
`timescale 1ns/1ps
module tb_top;
reg clk, rst_b, g_rst, g_ei, g_cu, hold, lpbk, pay_c, line_c;
reg [8:0] src;
wire [11:0] adr;
wire [31:0] wd;
wire [31:0] rdat;
wire [3:0] be;
wire [2:0] pay_sel, ifm, fsel;
wire [1:0] line_sel;
wire rd, wr, wreq, pay_ones, bert, bert_ck, ei_p, cu_p, pwr_dn, ck_en, dp_rst, p_rst, tlc, oe_b, gain, bout, rcp, rfp, tcp;
wire lf, tpp, tnp;
int err_count = 0;
int checked = 0;
int n_ei = 0;
int n_cu = 0;
int i;
logic [15:0] expq [$];
logic [11:0] ad [11] = '{12'h040, 12'h042, 12'h044, 12'h046, 12'h04a, 12'h04c, 12'h048, 12'h04e, 12'h058,
    12'h140, 12'h240};
logic [15:0] ms [11] = '{16'h7ede, 16'hf738, 16'h36ff, 16'h07ff, 16'h17ff, 16'h16de, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
logic [15:0] c2v [5] = '{16'h1100, 16'hc228, 16'h2000, 16'h1038, 16'h9100};
logic [9:0] c2e [5] = '{10'h048, 10'h315, 10'h180, 10'h107, 10'h248};
pcc_host_model host (.clk(clk), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_waitrequest(wreq));
pcc_port_regs dut (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .global_reset(g_rst), .global_error_insert(g_ei), .global_counter_update(g_cu), .counter_hold_done(hold),
    .rx_gapped_clock(src[0]), .rx_clock_output(src[1]), .rx_frame_start_out(src[2]), .rx_data_enable(src[3]),
    .tx_gapped_clock(src[4]), .tx_clock_output(src[5]), .tx_line_clock(src[6]), .tx_positive_out(src[7]),
    .tx_negative_out(src[8]), .diagnostic_loopback(lpbk), .payload_alarm_cond(pay_c), .line_alarm_cond(line_c),
    .payload_alarm_select(pay_sel), .payload_all_ones(pay_ones), .line_alarm_select(line_sel),
    .line_alarm_force(lf), .pattern_tester_enable(bert), .pattern_tester_clk_en(bert_ck),
    .error_insert_pulse(ei_p), .counter_update_pulse(cu_p), .port_power_down(pwr_dn), .port_clk_en(ck_en),
    .datapath_reset(dp_rst), .port_reset(p_rst), .tx_line_clock_pin(tlc),
    .tx_positive_pin(tpp), .tx_negative_pin(tnp),
    .tx_diff_oe_b(oe_b), .rx_monitor_gain(gain), .tx_build_out_active(bout), .interface_mode_sel(ifm),
    .framing_mode_sel(fsel), .rx_clock_pin(rcp), .rx_frame_pin(rfp), .tx_clock_pin(tcp));
// ****************************************
// Tasks and monitor
// ****************************************
task end_sim;
begin
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
        $display("DONE - PASS");
    else
        $display("DONE - FAIL");
    $finish;
end
endtask
task chk(input logic [15:0] got, input logic [15:0] exp);
begin
    checked++;
    if (got !== exp)
    begin
        err_count++;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
end
endtask
// Reads note their expected value for the monitor.
task bus(input logic w, input logic [11:0] a, input logic [15:0] d);
begin
    if (!w)
        expq.push_back(d);
    host.xfer(w, a, w ? d : 16'h0000);
end
endtask
task lag;
    repeat (2) @(negedge clk);
endtask
always @(posedge clk)
begin
    if (rd === 1'b1 && wreq === 1'b0)
    begin
        chk(rdat[15:0], expq.pop_front());
        chk(rdat[31:16], 16'h0000);
    end
    if (ei_p === 1'b1)
        n_ei++;
    if (cu_p === 1'b1)
        n_cu++;
end
initial
begin
    clk = 1'b0;
    forever
        #50 clk = ~clk;
end
initial
begin
    #1000000;
    err_count++;
    end_sim;
end
// ****************************************
// Tests
// ****************************************
initial
begin
    rst_b = 1'b0;
    {g_rst, g_ei, g_cu, hold, lpbk, pay_c, line_c} = 7'h00;
    src = 9'h000;
    void'($urandom(32'h4f84_9d57));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, 12'h040, 16'h0006);
    bus(1'b0, 12'h042, 16'h0000);
    bus(1'b0, 12'h052, 16'h0000);
    chk({5'h00, pwr_dn, dp_rst, oe_b, pay_ones, ifm, fsel, p_rst}, 16'h0780);
    $display("reset test ended");
    for (i = 0; i < 11; i++)
    begin
        bus(1'b1, ad[i], (i == 0) ? 16'hfffe : 16'hffff);
        bus(1'b0, ad[i], ms[i]);
    end
    $display("map test ended");
    bus(1'b1, 12'h040, 16'h0001);
    lag;
    chk({14'h0000, p_rst, dp_rst}, 16'h0003);
    bus(1'b1, 12'h040, 16'h0000);
    for (i = 0; i < 6; i++)
        bus(1'b0, ad[i], 16'h0000);
    @(posedge clk) g_rst <= 1'b1;
    lag;
    chk({14'h0000, p_rst, dp_rst}, 16'h0003);
    @(posedge clk) g_rst <= 1'b0;
    bus(1'b0, 12'h040, 16'h0006);
    $display("reset bit test ended");
    for (i = 0; i < 32; i++)
    begin
        @(posedge clk) {pay_c, line_c, lpbk} <= 3'($urandom);
        bus(1'b1, 12'h040, {1'b0, i[4:0], i[0], 9'h000});
        lag;
        chk({6'h00, pay_ones, lf, pay_sel, line_sel, bert, bert_ck, 1'b0},
            {6'h00, (i[4:2] == 3'h0) | pay_c, ((i[1:0] == 2'h0) ? lpbk : line_c), i[4:0], i[0], i[0], 1'b0});
    end
    $display("alarm test ended");
    n_ei = 0;
    n_cu = 0;
    bus(1'b1, 12'h040, 16'h0088);
    bus(1'b1, 12'h040, 16'h0088);
    @(posedge clk) hold <= 1'b1;
    bus(1'b0, 12'h052, 16'h0001);
    bus(1'b1, 12'h040, 16'h0000);
    bus(1'b0, 12'h052, 16'h0000);
    @(posedge clk) hold <= 1'b0;
    bus(1'b1, 12'h040, 16'h00d8);
    @(posedge clk) {g_ei, g_cu} <= 2'b11;
    lag;
    lag;
    chk({n_ei[7:0], n_cu[7:0]}, 16'h0202);
    @(posedge clk) {g_ei, g_cu} <= 2'b00;
    $display("event test ended");
    @(posedge clk) src <= 9'h1ff;
    for (i = 0; i < 5; i++)
    begin
        bus(1'b1, 12'h042, c2v[i]);
        lag;
        chk({6'h00, tlc, oe_b, gain, bout, ifm, fsel}, {6'h00, c2e[i]});
        chk({14'h0000, tpp, tnp}, {14'h0000, {2{c2e[i][9]}}});
    end
    $display("line test ended");
    for (i = 0; i < 4; i++)
    begin
        @(posedge clk) src <= i[1] ? 9'h026 : 9'h019;
        bus(1'b1, 12'h044, i[0] ? 16'h3400 : 16'h0000);
        lag;
        chk({13'h0000, rcp, rfp, tcp}, {13'h0000, {3{i[0] == i[1]}}});
    end
    bus(1'b1, 12'h040, 16'h0004);
    lag;
    chk({14'h0000, pwr_dn, ck_en}, 16'h0002);
    $display("pin test ended");
    end_sim;
end
endmodule // tb_top
